//--- core/lmalm_top.sv
// load monitor alarm block: settings, start delay, autoset, four monitors
`timescale 1ns/1ns
`include "lmalm_params.svh"
module lmalm_top
    import lmalm_pkg::*;
#(
    parameter int unsigned TICK_CYC = (`LMALM_CLK_HZ / 1000) * `LMALM_TICK_MS
) (
    input wire logic mclk, // system clock 20 MHz
    input wire logic rst_b, // async reset, low
    input wire logic run_cmd, // run command level, same clock
    input wire logic [7:0] shaft_power, // shaft power percent
    input wire logic [4:0] addr, // register address
    input wire logic [15:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [15:0] rdata, // read data, cycle after rd
    output logic [3:0] act_req, // per monitor request pulse
    output logic [11:0] act_code, // per monitor action code, 3 bits each
    output logic monitor_active, // start delay elapsed
    output logic autoset_fail // pulse when autoset refused
);
    lmalm_tick_if tk ();

    logic [2:0] act_ff [4];
    logic [2:0] nxt_act [4];
    logic [7:0] thr_ff [4];
    logic [7:0] nxt_thr [4];
    logic [9:0] dly_ff [4];
    logic [9:0] nxt_dly [4];
    logic [7:0] mar_ff [4];
    logic [7:0] nxt_mar [4];
    logic [9:0] sdly_ff;
    logic [9:0] nxt_sdly;
    logic [7:0] normal_ff;
    logic [7:0] nxt_normal;
    logic normal_on_ff;
    logic nxt_normal_on;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic autoset_fail_ff;
    logic nxt_autoset_fail;
    lmalm_state_t st_ff;
    lmalm_state_t nxt_st;
    logic [13:0] scnt_ff;
    logic [13:0] nxt_scnt;
    logic [3:0] req_w;
    logic [3:0] cond_w;
    logic [3:0] req_ff;
    logic [11:0] code_ff;
    logic [11:0] nxt_code;

    // legal action code check, illegal writes are ignored
    function automatic logic act_ok(input logic [2:0] a);
        return (a == 3'(LMALM_ACT_NONE)) || (a == 3'(LMALM_ACT_HARD)) ||
               (a == 3'(LMALM_ACT_SOFT)) || (a == 3'(LMALM_ACT_WARN));
    endfunction

    // saturating add/sub on the percent scale
    function automatic logic [7:0] pct_calc(input logic [7:0] b, input logic [7:0] m,
                                            input logic up);
        logic [8:0] s;
        s = 9'h0;
        if (up) begin
            s = {1'b0, b} + {1'b0, m};
            if (s > {1'b0, `LMALM_PCT_MAX}) begin
                s = {1'b0, `LMALM_PCT_MAX};
            end
        end else begin
            s = (m > b) ? 9'h0 : ({1'b0, b} - {1'b0, m});
        end
        return s[7:0];
    endfunction

    // 0.1 s tick divider
    lmalm_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
        .mclk(mclk),
        .rst_b(rst_b),
        .tk(tk)
    );

    // monitors 0,1 look for excess, 2,3 for shortfall
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mon
            lmalm_mon #(.IS_MAX(gi < 2)) u_mon (
                .mclk(mclk),
                .rst_b(rst_b),
                .tk(tk),
                .power(shaft_power),
                .thr(thr_ff[gi]),
                .dly(dly_ff[gi]),
                .act(act_ff[gi]),
                .req(req_w[gi]),
                .cond(cond_w[gi])
            );
        end
    endgenerate

    // start delay sequencer: stop, hold-off, monitoring
    always_comb begin
        nxt_st = st_ff;
        nxt_scnt = scnt_ff;
        unique case (st_ff)
            LMALM_ST_STOP: begin
                if (run_cmd) begin
                    nxt_st = LMALM_ST_HOLD;
                    nxt_scnt = 14'(sdly_ff) * 14'(`LMALM_TICKS_PER_S); // widen before the product
                end
            end
            LMALM_ST_HOLD: begin
                if (!run_cmd) begin
                    nxt_st = LMALM_ST_STOP;
                end else if (tk.tick) begin
                    if (scnt_ff <= 14'h1) begin
                        nxt_st = LMALM_ST_MON;
                    end else begin
                        nxt_scnt = scnt_ff - 14'h1;
                    end
                end
            end
            LMALM_ST_MON: begin
                if (!run_cmd) begin
                    nxt_st = LMALM_ST_STOP;
                end
            end
            default: begin
                nxt_st = LMALM_ST_STOP;
            end
        endcase
    end

    assign tk.enable = (st_ff == LMALM_ST_MON);

    // settings: manual writes, autoset capture
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_act[i] = act_ff[i];
            nxt_thr[i] = thr_ff[i];
            nxt_dly[i] = dly_ff[i];
            nxt_mar[i] = mar_ff[i];
        end
        nxt_sdly = sdly_ff;
        nxt_normal = normal_ff;
        nxt_normal_on = normal_on_ff;
        nxt_autoset_fail = 1'b0;
        if (wr) begin
            for (int i = 0; i < 4; i++) begin
                if ((addr == 5'(`LMALM_A_OVA_ACT + i)) && act_ok(wdata[2:0])
                    && (wdata[15:3] == 13'h0)) begin
                    nxt_act[i] = wdata[2:0];
                end
                if ((addr == 5'(`LMALM_A_OVA_THR + i)) && (wdata[7:0] <= `LMALM_PCT_MAX)
                    && (wdata[15:8] == 8'h0)) begin
                    nxt_thr[i] = wdata[7:0];
                    nxt_normal_on = 1'b0;
                end
                if ((addr == 5'(`LMALM_A_OVA_DLY + i)) && (wdata[9:0] >= `LMALM_DLY_MIN)
                    && (wdata[9:0] <= `LMALM_DLY_MAX) && (wdata[15:10] == 6'h0)) begin
                    nxt_dly[i] = wdata[9:0];
                end
                if ((addr == 5'(`LMALM_A_OVA_MAR + i)) && (wdata[7:0] <= `LMALM_PCT_MAX)
                    && (wdata[15:8] == 8'h0)) begin
                    nxt_mar[i] = wdata[7:0]; // margins do not move thresholds alone
                end
            end
            if ((addr == `LMALM_A_SDLY) && (wdata[9:0] >= `LMALM_SDLY_MIN)
                && (wdata[9:0] <= `LMALM_SDLY_MAX) && (wdata[15:10] == 6'h0)) begin
                nxt_sdly = wdata[9:0];
            end
            if ((addr == `LMALM_A_AUTOSET) && wdata[0]) begin
                if (st_ff == LMALM_ST_MON) begin
                    nxt_normal = shaft_power;
                    nxt_normal_on = 1'b1;
                    for (int i = 0; i < 4; i++) begin
                        nxt_thr[i] = pct_calc(shaft_power, mar_ff[i], i < 2);
                    end
                end else begin
                    nxt_autoset_fail = 1'b1; // not running or start delay pending
                end
            end
        end
    end

    // read mux, data stands the cycle after rd
    always_comb begin
        nxt_rdata = 16'h0;
        if (rd) begin
            for (int i = 0; i < 4; i++) begin
                if (addr == 5'(`LMALM_A_OVA_ACT + i)) nxt_rdata = {13'h0, act_ff[i]};
                if (addr == 5'(`LMALM_A_OVA_THR + i)) nxt_rdata = {8'h0, thr_ff[i]};
                if (addr == 5'(`LMALM_A_OVA_DLY + i)) nxt_rdata = {6'h0, dly_ff[i]};
                if (addr == 5'(`LMALM_A_OVA_MAR + i)) nxt_rdata = {8'h0, mar_ff[i]};
            end
            if (addr == `LMALM_A_SDLY) nxt_rdata = {6'h0, sdly_ff};
            if (addr == `LMALM_A_NORMAL) nxt_rdata = {7'h0, normal_on_ff, normal_ff};
            if (addr == `LMALM_A_STATUS) nxt_rdata = {11'h0, tk.enable, cond_w};
            if (addr == `LMALM_A_POWER) nxt_rdata = {8'h0, shaft_power};
        end
    end

    // action code travels with each request pulse
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_code[3*i +: 3] = req_w[i] ? act_ff[i] : 3'h0;
        end
    end

    // register everything
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                act_ff[i] <= 3'(LMALM_ACT_NONE);
                dly_ff[i] <= `LMALM_DLY_RST;
            end
            thr_ff[0] <= `LMALM_OVA_THR_RST;
            thr_ff[1] <= `LMALM_OVP_THR_RST;
            thr_ff[2] <= `LMALM_UNP_THR_RST;
            thr_ff[3] <= `LMALM_UNA_THR_RST;
            mar_ff[0] <= `LMALM_OVA_MAR_RST;
            mar_ff[1] <= `LMALM_OVP_MAR_RST;
            mar_ff[2] <= `LMALM_UNP_MAR_RST;
            mar_ff[3] <= `LMALM_UNA_MAR_RST;
            sdly_ff <= `LMALM_SDLY_RST;
            normal_ff <= 8'h0;
            normal_on_ff <= 1'b0;
            rdata_ff <= 16'h0;
            autoset_fail_ff <= 1'b0;
            st_ff <= LMALM_ST_STOP;
            scnt_ff <= 14'h0;
            req_ff <= 4'h0;
            code_ff <= 12'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                act_ff[i] <= nxt_act[i];
                thr_ff[i] <= nxt_thr[i];
                dly_ff[i] <= nxt_dly[i];
                mar_ff[i] <= nxt_mar[i];
            end
            sdly_ff <= nxt_sdly;
            normal_ff <= nxt_normal;
            normal_on_ff <= nxt_normal_on;
            rdata_ff <= nxt_rdata;
            autoset_fail_ff <= nxt_autoset_fail;
            st_ff <= nxt_st;
            scnt_ff <= nxt_scnt;
            req_ff <= req_w;
            code_ff <= nxt_code;
        end
    end

    assign rdata = rdata_ff;
    assign act_req = req_ff;
    assign act_code = code_ff;
    assign monitor_active = (st_ff == LMALM_ST_MON);
    assign autoset_fail = autoset_fail_ff;
endmodule // lmalm_top

//--- core/lmalm_params.svh
// constants for the load monitor alarm block
// Functional notes
// - thresholds and power in percent of nominal
// - separate action setting per monitor
// - action codes 0,1,3,4; reset none
// - overload alarm threshold 0-200, default 116
// - power above overload alarm starts timer
// - overload actions need uninterrupted excess beyond delay
// - overload prewarn threshold 0-200, default 108
// - power above overload prewarn starts timer
// - underload prewarn threshold 0-200, default 92
// - underload alarm threshold 0-200, default 84
// - power below minimum thresholds starts timer
// - underload actions need uninterrupted dip beyond delay
// - delays 0.1 to 90 s, default 0.5
// - thresholds written manually or by autoset
// - start delay gates monitoring during start
// - start delay 1-999 s, default 10
// - autoset stores load, recomputes thresholds with margins
// - manual threshold write cancels autoset, load off
`ifndef LMALM_PARAMS_SVH
`define LMALM_PARAMS_SVH
`define LMALM_CLK_HZ 20000000
`define LMALM_TICK_MS 100
`define LMALM_PCT_MAX 8'hc8
`define LMALM_OVA_THR_RST 8'h74
`define LMALM_OVP_THR_RST 8'h6c
`define LMALM_UNP_THR_RST 8'h5c
`define LMALM_UNA_THR_RST 8'h54
`define LMALM_DLY_MIN 10'h001
`define LMALM_DLY_MAX 10'h384
`define LMALM_DLY_RST 10'h005
`define LMALM_SDLY_MIN 10'h001
`define LMALM_SDLY_MAX 10'h3e7
`define LMALM_SDLY_RST 10'h00a
`define LMALM_TICKS_PER_S 4'ha
`define LMALM_OVA_MAR_RST 8'h10
`define LMALM_OVP_MAR_RST 8'h08
`define LMALM_UNP_MAR_RST 8'h08
`define LMALM_UNA_MAR_RST 8'h10
`define LMALM_A_OVA_ACT 5'h00
`define LMALM_A_OVP_ACT 5'h01
`define LMALM_A_UNP_ACT 5'h02
`define LMALM_A_UNA_ACT 5'h03
`define LMALM_A_OVA_THR 5'h04
`define LMALM_A_OVP_THR 5'h05
`define LMALM_A_UNP_THR 5'h06
`define LMALM_A_UNA_THR 5'h07
`define LMALM_A_OVA_DLY 5'h08
`define LMALM_A_OVP_DLY 5'h09
`define LMALM_A_UNP_DLY 5'h0a
`define LMALM_A_UNA_DLY 5'h0b
`define LMALM_A_OVA_MAR 5'h0c
`define LMALM_A_OVP_MAR 5'h0d
`define LMALM_A_UNP_MAR 5'h0e
`define LMALM_A_UNA_MAR 5'h0f
`define LMALM_A_SDLY 5'h10
`define LMALM_A_AUTOSET 5'h11
`define LMALM_A_NORMAL 5'h12
`define LMALM_A_STATUS 5'h13
`define LMALM_A_POWER 5'h14
`endif

//--- core/lmalm_pkg.sv
// types for the load monitor alarm block
package lmalm_pkg;
    typedef enum logic [2:0] {
        LMALM_ACT_NONE = 3'h0,
        LMALM_ACT_HARD = 3'h1,
        LMALM_ACT_SOFT = 3'h3,
        LMALM_ACT_WARN = 3'h4
    } lmalm_act_t;
    typedef enum logic [2:0] {
        LMALM_ST_STOP = 3'b001,
        LMALM_ST_HOLD = 3'b010,
        LMALM_ST_MON = 3'b100
    } lmalm_state_t;
endpackage

//--- core/lmalm_tick_if.sv
// tick and gating signals shared between the alarm block's modules
`timescale 1ns/1ns
interface lmalm_tick_if;
    logic tick; // one-cycle 0.1 s enable
    logic enable; // monitoring active
    modport src (output tick, input enable);
    modport dst (input tick, input enable);
endinterface

//--- core/lmalm_tick_gen.sv
// divider that makes the 0.1 s enable pulse
`timescale 1ns/1ns
`include "lmalm_params.svh"
module lmalm_tick_gen
    import lmalm_pkg::*;
#(
    parameter int unsigned TICK_CYC = (`LMALM_CLK_HZ / 1000) * `LMALM_TICK_MS
) (
    input wire logic mclk, // system clock
    input wire logic rst_b, // async reset, low
    lmalm_tick_if.src tk // tick out
);
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    // count down one tick period
    always_comb begin
        nxt_tick = 1'b0;
        if (cnt_ff == 32'h0) begin
            nxt_cnt = 32'(TICK_CYC - 1);
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff - 32'h1;
        end
    end

    // register divider
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tk.tick = tick_ff;
endmodule // lmalm_tick_gen

//--- core/lmalm_mon.sv
// one threshold monitor with its qualifying delay timer
`timescale 1ns/1ns
`include "lmalm_params.svh"
module lmalm_mon
    import lmalm_pkg::*;
#(
    parameter bit IS_MAX = 1'b1
) (
    input wire logic mclk, // system clock
    input wire logic rst_b, // async reset, low
    lmalm_tick_if.dst tk, // tick and enable
    input wire logic [7:0] power, // shaft power percent
    input wire logic [7:0] thr, // threshold percent
    input wire logic [9:0] dly, // delay in 0.1 s
    input wire logic [2:0] act, // action code
    output logic req, // request pulse
    output logic cond // condition present
);
    logic [9:0] tmr_ff;
    logic [9:0] nxt_tmr;
    logic fired_ff;
    logic nxt_fired;
    logic req_ff;
    logic nxt_req;
    logic exc;

    // comparison on the percent scale
    assign exc = IS_MAX ? (power > thr) : (power < thr);

    // timer: reload off condition, count ticks while it holds
    always_comb begin
        nxt_tmr = tmr_ff;
        nxt_fired = fired_ff;
        nxt_req = 1'b0;
        if (!exc || !tk.enable) begin
            nxt_tmr = dly;
            nxt_fired = 1'b0;
        end else if (tk.tick && !fired_ff) begin
            if (tmr_ff == 10'h0) begin
                nxt_fired = 1'b1;
                nxt_req = (act != 3'(LMALM_ACT_NONE));
            end else begin
                nxt_tmr = tmr_ff - 10'h1;
            end
        end
    end

    // register timer state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_ff <= `LMALM_DLY_RST;
            fired_ff <= 1'b0;
            req_ff <= 1'b0;
        end else begin
            tmr_ff <= nxt_tmr;
            fired_ff <= nxt_fired;
            req_ff <= nxt_req;
        end
    end

    assign req = req_ff;
    assign cond = exc;
endmodule // lmalm_mon

//--- tb/lmalm_top_monitor.sv
// port checker for the load monitor alarm block
`timescale 1ns/1ns
module lmalm_top_monitor
    import lmalm_pkg::*;
#(
    parameter int unsigned TICK_CYC = 10
) (
    input wire logic mclk, // clock
    input wire logic rst_b, // reset
    input wire logic run_cmd, // run
    input wire logic [7:0] shaft_power, // power
    input wire logic [4:0] addr, // address
    input wire logic [15:0] wdata, // data
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [15:0] rdata, // read data
    input wire logic [3:0] act_req, // requests
    input wire logic [11:0] act_code, // codes
    input wire logic monitor_active, // active
    input wire logic autoset_fail // refused
);
    // legal nonzero action code
    function automatic logic ok_code(input logic [2:0] c);
        return c == 3'h1 || c == 3'h3 || c == 3'h4;
    endfunction
    // code bits of monitors that are not requesting
    logic [11:0] idle_code;
    assign idle_code = act_code & ~{{3{act_req[3]}}, {3{act_req[2]}},
        {3{act_req[1]}}, {3{act_req[0]}}};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    code_idle_a: assert property (idle_code == 12'h000)
        else $error("action code without request");
    code_legal_a: assert property ((!act_req[0] || ok_code(act_code[2:0]))
        && (!act_req[1] || ok_code(act_code[5:3])) && (!act_req[2] || ok_code(act_code[8:6]))
        && (!act_req[3] || ok_code(act_code[11:9]))) else $error("bad action code");
    req_pulse_a: assert property (act_req != 4'h0 |=> (act_req & $past(act_req)) == 4'h0)
        else $error("request longer than one cycle");
    req_gated_a: assert property (act_req != 4'h0 |->
        $past(monitor_active, 2) || $past(monitor_active, 3)) else $error("request while held off");
    active_run_a: assert property (monitor_active |-> $past(run_cmd))
        else $error("active without run");
    hold_off_a: assert property ($rose(run_cmd) |=> !monitor_active [*8])
        else $error("start delay too short");
    fail_pulse_a: assert property (wr && addr == 5'h11 && wdata[0] && !monitor_active
        |=> autoset_fail) else $error("autoset not refused");
    fail_cause_a: assert property (autoset_fail |-> $past(wr) && $past(addr) == 5'h11)
        else $error("refusal without autoset");
    power_read_a: assert property ($past(rd) && $past(addr) == 5'h14
        |-> rdata == {8'h00, $past(shaft_power)}) else $error("power read wrong");
    status_read_a: assert property ($past(rd) && $past(addr) == 5'h13
        |-> rdata[15:4] == {11'h000, $past(monitor_active)}) else $error("status read wrong");
endmodule // lmalm_top_monitor
bind lmalm_top lmalm_top_monitor #(.TICK_CYC(TICK_CYC)) u_mon (.mclk(mclk), .rst_b(rst_b),
    .run_cmd(run_cmd), .shaft_power(shaft_power), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .act_req(act_req), .act_code(act_code),
    .monitor_active(monitor_active), .autoset_fail(autoset_fail));

//--- tb/lmalm_plant.sv
// motor side model: power and run source, request counter
`timescale 1ns/1ns
module lmalm_plant
    import lmalm_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst_b, // reset
    input wire logic [7:0] power_set, // wanted power
    input wire logic run_set, // wanted run
    input wire logic clr, // clear counts
    input wire logic [3:0] act_req, // requests
    input wire logic [11:0] act_code, // codes
    output logic [7:0] shaft_power, // power percent
    output logic run_cmd, // run level
    output logic [31:0] cnt, // 8 bits per monitor
    output logic [11:0] codes // last code per monitor
);
    // drive measurement, count trip requests
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            shaft_power <= 8'h00;
            run_cmd <= 1'b0;
            cnt <= 32'h0;
            codes <= 12'h000;
        end else begin
            shaft_power <= power_set;
            run_cmd <= run_set;
            for (int i = 0; i < 4; i++) begin
                if (clr) begin
                    cnt[8*i+:8] <= 8'h00;
                end else if (act_req[i]) begin
                    cnt[8*i+:8] <= cnt[8*i+:8] + 8'h01;
                    codes[3*i+:3] <= act_code[3*i+:3];
                end
            end
        end
    end
endmodule // lmalm_plant

//--- tb/lmalm_top_tb_top.sv
// self-checking bench for the load monitor alarm block
`timescale 1ns/1ns
module lmalm_top_tb_top
    import lmalm_pkg::*;
;
    logic mclk, rst_b, wr, rd, clr, run_set, run_cmd, monitor_active, autoset_fail;
    logic [7:0] power_set, shaft_power;
    logic [4:0] addr;
    logic [15:0] wdata, rdata;
    logic [3:0] act_req;
    logic [11:0] act_code, codes;
    logic [31:0] cnt, seed, r;
    int mismatches, total_checks, nrm, nv, running, pw, n, a, d;
    int m[0:16];
    int cfg[38] = '{4, 200, 4, 201, 8, 900, 8, 901, 8, 0, 16, 1000, 0, 2, 0, 1, 1, 4, 2, 3,
        3, 0, 8, 1, 9, 3, 10, 5, 16, 1, 12, 120, 13, 10, 14, 20, 15, 150};
    // clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    lmalm_top #(.TICK_CYC(10)) u_dut (.mclk(mclk), .rst_b(rst_b), .run_cmd(run_cmd),
        .shaft_power(shaft_power), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .act_req(act_req), .act_code(act_code),
        .monitor_active(monitor_active), .autoset_fail(autoset_fail));
    lmalm_plant u_plant (.mclk(mclk), .rst_b(rst_b), .power_set(power_set),
        .run_set(run_set), .clr(clr), .act_req(act_req), .act_code(act_code),
        .shaft_power(shaft_power), .run_cmd(run_cmd), .cnt(cnt), .codes(codes));
    // xorshift source
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // register model: accept ranges, autoset, manual cancel
    function automatic void mwr(input int a, input int d);
        logic ok;
        ok = a <= 3 ? (d == 0 || d == 1 || d == 3 || d == 4) : (a <= 7 || (a >= 12 && a <= 15))
            ? d <= 200 : a <= 11 ? (d >= 1 && d <= 900) : a == 16 ? (d >= 1 && d <= 999) : 1'b0;
        if (ok) m[a] = d;
        if (ok && a >= 4 && a <= 7) nv = 0;
        if (a == 17 && d % 2 == 1 && running == 1) begin
            nrm = pw;
            nv = 1;
            m[4] = pw + m[12] > 200 ? 200 : pw + m[12];
            m[5] = pw + m[13] > 200 ? 200 : pw + m[13];
            m[6] = pw < m[14] ? 0 : pw - m[14];
            m[7] = pw < m[15] ? 0 : pw - m[15];
        end
    endfunction
    function automatic logic [15:0] mrd(input int a);
        // normal load keeps its last value; bit 8 alone says whether it is valid
        return a <= 16 ? 16'(m[a]) : a == 18 ? 16'(nv * 256 + nrm) : 16'h0000;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic wreg(input int a, input int d);
        @(posedge mclk);
        addr <= 5'(a);
        wdata <= 16'(d);
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        mwr(a, d);
    endtask
    task automatic rd_chk(input int a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= 5'(a);
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic doclr();
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        wrap_up;
    end
    // main sequence
    initial begin
        rst_b = 1'b0;
        {wr, rd, clr, run_set, addr, wdata} = '0;
        power_set = 8'h64;
        seed = 32'h9fa6;
        running = 0;
        pw = 100;
        nrm = 0;
        nv = 0;
        m = '{0, 0, 0, 0, 116, 108, 92, 84, 5, 5, 5, 5, 16, 8, 8, 16, 10};
        cyc(20);
        rst_b <= 1'b1;
        for (a = 0; a <= 18; a++) if (a != 17) rd_chk(a, mrd(a));
        rd_chk(31, 16'h0000);
        repeat (40) begin
            r = rnd();
            a = int'(r[15:0] % 17);
            d = r[20] ? int'(r[31:23]) : int'(r[31:29]);
            wreg(a, d);
            rd_chk(a, mrd(a));
        end
        for (int i = 0; i < 38; i += 2) begin
            wreg(cfg[i], cfg[i+1]);
            rd_chk(cfg[i], mrd(cfg[i]));
        end
        wreg(17, 1);
        #1 check(autoset_fail, 1'b1);
        run_set <= 1'b1;
        n = 0;
        while (monitor_active !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(n >= 89 && n <= 106, 1'b1);
        running = 1;
        wreg(17, 1);
        for (a = 4; a <= 7; a++) rd_chk(a, mrd(a));
        rd_chk(18, mrd(18));
        wreg(4, 150);
        wreg(7, 60);
        rd_chk(18, mrd(18));
        doclr();
        power_set <= 8'h6e;
        cyc(80);
        repeat (3) begin
            power_set <= 8'h82;
            cyc(25);
            power_set <= 8'h64;
            cyc(15);
        end
        check(cnt[15:8], 8'h00);
        power_set <= 8'h82;
        n = 0;
        while (cnt[15:8] == 8'h00 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(n >= 30 && n <= 45, 1'b1);
        cyc(60);
        check(cnt[15:8], 8'h01);
        check(codes[5:3], LMALM_ACT_WARN);
        doclr();
        power_set <= 8'ha0;
        cyc(80);
        check(cnt[15:0], 16'h0001);
        check(codes[2:0], LMALM_ACT_HARD);
        doclr();
        power_set <= 8'h32;
        cyc(100);
        check(cnt[31:16], 16'h0001);
        check(codes[8:6], LMALM_ACT_SOFT);
        rd_chk(19, 16'h001c);
        rd_chk(20, 16'h0032);
        run_set <= 1'b0;
        cyc(3);
        check(monitor_active, 1'b0);
        wrap_up;
    end
endmodule // lmalm_top_tb_top
